// file: rtl/cmcl_map.vh
`ifndef CMCL_MAP_VH
`define CMCL_MAP_VH
// register byte addresses
`define CMCL_A_MODE    8'h00
`define CMCL_A_LOAD    8'h04
`define CMCL_A_HOLD    8'h08
`define CMCL_A_COUNT   8'h0C
`define CMCL_A_CMD     8'h10
`define CMCL_A_STATUS  8'h14
// mode register reset value and fields
`define CMCL_MODE_RST  16'h0800
`define CMCL_F_OUT_LO  0
`define CMCL_F_OUT_HI  2
`define CMCL_F_UP      3
`define CMCL_F_BCD     4
`define CMCL_F_REPEAT  5
`define CMCL_F_RELOAD  6
`define CMCL_F_SPECIAL 7
`define CMCL_F_SRC_LO  8
`define CMCL_F_SRC_HI  11
`define CMCL_F_POL     12
`define CMCL_F_GATE_LO 13
`define CMCL_F_GATE_HI 15
// output field codes
`define CMCL_OUT_LOW   3'h0
`define CMCL_OUT_TCH   3'h1
`define CMCL_OUT_TOG   3'h2
`define CMCL_OUT_OFF   3'h4
`define CMCL_OUT_TCL   3'h5
// gating field codes
`define CMCL_G_NONE    3'h0
`define CMCL_G_LOWTC   3'h1
`define CMCL_G_HIGHER  3'h2
`define CMCL_G_LOWER   3'h3
`define CMCL_G_OWNHI   3'h4
`define CMCL_G_OWNLO   3'h5
`define CMCL_G_EDGER   3'h6
`define CMCL_G_EDGEF   3'h7
// command register bits
`define CMCL_C_ARM     0
`define CMCL_C_LOAD    1
`define CMCL_C_LDARM   2
`define CMCL_C_DISSAVE 3
`define CMCL_C_SAVE    4
`define CMCL_C_DISARM  5
`define CMCL_C_SETOUT  6
`define CMCL_C_CLROUT  7
`define CMCL_C_STEP    8
// status register bits
`define CMCL_S_ARMED   0
`define CMCL_S_TC      1
`define CMCL_S_TOGGLE  2
`define CMCL_S_RETRIG  3
`define CMCL_S_RUN     4
// terminal-count precursors
`define CMCL_PRE_DOWN  16'h0001
`define CMCL_PRE_BCD   16'h9999
`define CMCL_PRE_BIN   16'hFFFF
`endif

// file: rtl/cmcl_counter.v
// Overview of operation
// - output field picks off, driven low, high TC pulse, low TC pulse or toggle
// - terminal count follows the count from 0001 down, 9999 BCD up, FFFF binary up
// - terminal count lasts at most one source period regardless of gating or arming, unless the reload value is the pre-terminal value
// - every terminal count reloads the counter from the chosen load or hold register
// - toggled output flips on each trailing terminal-count edge
// - host set and clear output commands force the toggle flip-flop
// - counter at pre-terminal value is committed; retrigger or load cannot delay it
// - load before terminal count enters it at once; load during it ends it
// - during terminal count the next source edge counts even if disarmed or gated off
// - reload of pre-terminal value keeps terminal count and toggles on every count
// - independent up/down and BCD/binary bits combine with all other settings
// - repeat set runs until disarmed; clear disarms after one or two terminal counts
// - reload bit 0 reloads from load; 1 picks load/hold by gate or alternation
// - retrigger gate edge saves count to hold; next qualified edge loads load value
// - load or step after a retrigger edge acts as that edge and loads load value
// - with gating, special bit 0 blocks retriggering and 1 retriggers on gate edges
// - without gating, special bit 1 lets gate level pick hold or load for reload
// - polarity bit 0 counts rising source edges and 1 counts falling ones
// - four-bit field picks one of 16 inputs including lower neighbour terminal count
// - gating 000 runs freely, 100 counts on own gate high, 101 on own gate low
// - gating 010/011 use neighbour gates, 001 lower terminal count, counters wrap
// - gating 110/111 start on gate edge and run one cycle; repeat rearms on edge
// - mode register resets to 0800 hex
`timescale 1ns/1ps
`default_nettype none
`include "cmcl_map.vh"

module cmcl_counter #(
  parameter CTR_IDX = 0,                        // this counter's position, 0 to 4
  parameter NCTR    = 5                         // counters in the ring
) (
  input  wire        i_mclk,                    // system clock, 40 MHz
  input  wire        i_rstn,                    // synchronous reset, active low
  input  wire [7:0]  i_addr,                    // register byte address
  input  wire [15:0] i_wdata,                   // register write data
  input  wire        i_wr,                      // write strobe
  input  wire        i_rd,                      // read strobe
  output reg  [15:0] o_rdata,                   // read data, cycle after i_rd
  input  wire [4:0]  i_freq,                    // divided oscillator frequencies
  input  wire [4:0]  i_src_pins,                // source input pins
  input  wire [4:0]  i_gate_pins,               // gating pins of all counters
  input  wire        i_lower_tc,                // lower neighbour terminal count
  output reg         o_tc,                      // terminal count level
  output reg         o_out,                     // result pin level
  output reg         o_out_oe                   // result pin drive enable
);

  localparam HI_IDX = (CTR_IDX + 1) % NCTR;
  localparam LO_IDX = (CTR_IDX + NCTR - 1) % NCTR;

  function [15:0] cmcl_next;
    input [15:0] v;
    input        up;
    input        bcd;
    reg   [3:0]  d;
    reg          c;
    integer      i;
    begin
      cmcl_next = v;
      c = 1'b1;
      if (!bcd) begin
        cmcl_next = up ? v + 16'h0001 : v - 16'h0001;
      end else begin
        for (i = 0; i < 4; i = i + 1) begin
          d = v[i*4 +: 4];
          if (c) begin
            if (up) begin
              c = (d == 4'h9);
              d = c ? 4'h0 : d + 4'h1;
            end else begin
              c = (d == 4'h0);
              d = c ? 4'h9 : d - 4'h1;
            end
          end
          cmcl_next[i*4 +: 4] = d;
        end
      end
    end
  endfunction

  reg  [15:0] mode_q;
  reg  [15:0] load_q;
  reg  [15:0] hold_q;
  reg  [15:0] cnt_q;
  reg         tc_q;
  reg         tog_q;
  reg         armed_q;
  reg         dis_pend_q;
  reg         retrig_q;
  reg         run_q;
  reg         alt_q;
  reg  [1:0]  tcn_q;
  reg  [9:0]  s1_q;
  reg  [9:0]  s2_q;
  reg  [9:0]  s3_q;
  reg  [9:0]  stab_q;
  reg         src_prev_q;
  reg         gate_prev_q;

  wire [2:0]  out_f   = mode_q[`CMCL_F_OUT_HI:`CMCL_F_OUT_LO];
  wire        up      = mode_q[`CMCL_F_UP];
  wire        bcd     = mode_q[`CMCL_F_BCD];
  wire        rep     = mode_q[`CMCL_F_REPEAT];
  wire        rel_bit = mode_q[`CMCL_F_RELOAD];
  wire        spec    = mode_q[`CMCL_F_SPECIAL];
  wire [3:0]  src_f   = mode_q[`CMCL_F_SRC_HI:`CMCL_F_SRC_LO];
  wire        pol     = mode_q[`CMCL_F_POL];
  wire [2:0]  gate_f  = mode_q[`CMCL_F_GATE_HI:`CMCL_F_GATE_LO];

  wire [4:0]  src_s   = stab_q[4:0];
  wire [4:0]  gate_s  = stab_q[9:5];

  // command strobes
  wire        cmd_wr  = i_wr && (i_addr == `CMCL_A_CMD);
  wire        c_arm   = cmd_wr && (i_wdata[`CMCL_C_ARM] || i_wdata[`CMCL_C_LDARM]);
  wire        c_load  = cmd_wr && (i_wdata[`CMCL_C_LOAD] || i_wdata[`CMCL_C_LDARM]);
  wire        c_save  = cmd_wr && (i_wdata[`CMCL_C_SAVE] || i_wdata[`CMCL_C_DISSAVE]);
  wire        c_dis   = cmd_wr && (i_wdata[`CMCL_C_DISARM] || i_wdata[`CMCL_C_DISSAVE]);
  wire        c_set   = cmd_wr && i_wdata[`CMCL_C_SETOUT];
  wire        c_clr   = cmd_wr && i_wdata[`CMCL_C_CLROUT];
  wire        c_step  = cmd_wr && i_wdata[`CMCL_C_STEP];

  // count source selection and edge
  wire [15:0] src_vec = {gate_s[4:2], i_freq, gate_s[1:0], src_s, i_lower_tc};
  wire        src_lvl = src_vec[src_f];
  wire        src_edge = pol ? (src_prev_q && !src_lvl)
                             : (src_lvl && !src_prev_q);

  // gating signal at its active level
  reg         gate_lvl;
  always @* begin
    case (gate_f)
      `CMCL_G_LOWTC:  gate_lvl = i_lower_tc;
      `CMCL_G_HIGHER: gate_lvl = gate_s[HI_IDX];
      `CMCL_G_LOWER:  gate_lvl = gate_s[LO_IDX];
      `CMCL_G_OWNHI:  gate_lvl = gate_s[CTR_IDX];
      `CMCL_G_OWNLO:  gate_lvl = !gate_s[CTR_IDX];
      `CMCL_G_EDGER:  gate_lvl = gate_s[CTR_IDX];
      `CMCL_G_EDGEF:  gate_lvl = !gate_s[CTR_IDX];
      default:        gate_lvl = 1'b1;
    endcase
  end

  wire        edge_mode = (gate_f == `CMCL_G_EDGER) || (gate_f == `CMCL_G_EDGEF);
  wire        gate_edge = gate_lvl && !gate_prev_q && (gate_f != `CMCL_G_NONE);
  wire        gate_ok   = (gate_f == `CMCL_G_NONE) ? 1'b1 :
                          edge_mode ? run_q : gate_lvl;
  wire        retrig_en = (gate_f != `CMCL_G_NONE) && spec;

  // reload source
  wire        by_gate = (gate_f == `CMCL_G_NONE) && spec;
  wire        use_hold = rel_bit && (by_gate ? gate_s[CTR_IDX] : alt_q);
  wire [15:0] reload  = use_hold ? hold_q : load_q;

  wire [15:0] pre_val = !up ? `CMCL_PRE_DOWN :
                        bcd ? `CMCL_PRE_BCD : `CMCL_PRE_BIN;
  wire        commit  = (cnt_q == pre_val);

  // while in terminal count any source edge counts
  wire        src_cnt = src_edge && ((armed_q && gate_ok) || tc_q);
  wire        cnt_ev  = src_cnt || c_step;
  wire        any_ev  = cnt_ev || c_load;
  wire        tc_d    = any_ev ? commit : tc_q;
  wire        tc_fall = tc_q && any_ev;
  wire [1:0]  tc_need = rel_bit ? 2'h2 : 2'h1;
  wire        cyc_end = tc_fall && (tcn_q == tc_need);
  wire        dis_now = tc_fall && (dis_pend_q || c_dis || (cyc_end && !rep));

  // input synchronisers: stable once stages two and three agree
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      s1_q   <= 10'h000;
      s2_q   <= 10'h000;
      s3_q   <= 10'h000;
      stab_q <= 10'h000;
    end else begin
      s1_q   <= {i_gate_pins, i_src_pins};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stab_q <= (s2_q & s3_q) | (stab_q & (s2_q ^ s3_q));
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      mode_q      <= `CMCL_MODE_RST;
      load_q      <= 16'h0000;
      hold_q      <= 16'h0000;
      cnt_q       <= 16'h0000;
      tc_q        <= 1'b0;
      tog_q       <= 1'b0;
      armed_q     <= 1'b0;
      dis_pend_q  <= 1'b0;
      retrig_q    <= 1'b0;
      run_q       <= 1'b0;
      alt_q       <= 1'b0;
      tcn_q       <= 2'h0;
      src_prev_q  <= 1'b0;
      gate_prev_q <= 1'b0;
    end else begin
      src_prev_q  <= src_lvl;
      gate_prev_q <= gate_lvl;
      if (i_wr && i_addr == `CMCL_A_MODE)
        mode_q <= i_wdata;
      if (i_wr && i_addr == `CMCL_A_LOAD)
        load_q <= i_wdata;

      // counting path
      if (any_ev) begin
        if (commit) begin
          cnt_q    <= reload;
          retrig_q <= 1'b0;
          alt_q    <= !alt_q;
          if (tcn_q != tc_need)
            tcn_q <= tcn_q + 2'h1;
        end else if (retrig_q) begin
          cnt_q    <= load_q;
          retrig_q <= 1'b0;
        end else if (c_load) begin
          cnt_q    <= reload;
        end else begin
          cnt_q    <= cmcl_next(cnt_q, up, bcd);
        end
      end
      tc_q <= tc_d;

      // hold register: software write, save commands, retrigger capture
      if (retrig_en && gate_edge && armed_q && !commit) begin
        hold_q   <= cnt_q;
        retrig_q <= 1'b1;
      end else if (c_save) begin
        hold_q <= cnt_q;
      end else if (i_wr && i_addr == `CMCL_A_HOLD) begin
        hold_q <= i_wdata;
      end

      // toggle flip-flop
      if (c_set)
        tog_q <= 1'b1;
      else if (c_clr)
        tog_q <= 1'b0;
      else if (tc_fall)
        tog_q <= !tog_q;

      // edge gated run window
      if (edge_mode && gate_edge && armed_q)
        run_q <= 1'b1;
      else if (cyc_end || !edge_mode)
        run_q <= 1'b0;

      if (cyc_end)
        tcn_q <= 2'h0;

      // arming
      if (c_arm) begin
        armed_q    <= 1'b1;
        dis_pend_q <= 1'b0;
        alt_q      <= 1'b1;
        tcn_q      <= 2'h0;
      end else if (dis_now) begin
        armed_q    <= 1'b0;
        dis_pend_q <= 1'b0;
      end else if (c_dis) begin
        if (tc_q)
          dis_pend_q <= 1'b1;
        else
          armed_q <= 1'b0;
      end
    end
  end

  // outputs and read data
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_rdata  <= 16'h0000;
      o_tc     <= 1'b0;
      o_out    <= 1'b0;
      o_out_oe <= 1'b1;
    end else begin
      o_tc     <= tc_d;
      o_out_oe <= (out_f != `CMCL_OUT_OFF);
      case (out_f)
        `CMCL_OUT_TCH: o_out <= tc_d;
        `CMCL_OUT_TCL: o_out <= !tc_d;
        `CMCL_OUT_TOG: o_out <= tog_q;
        default:       o_out <= 1'b0;
      endcase
      o_rdata <= 16'h0000;
      if (i_rd) begin
        case (i_addr)
          `CMCL_A_MODE:   o_rdata <= mode_q;
          `CMCL_A_LOAD:   o_rdata <= load_q;
          `CMCL_A_HOLD:   o_rdata <= hold_q;
          `CMCL_A_COUNT:  o_rdata <= cnt_q;
          `CMCL_A_STATUS: o_rdata <= {11'h000, run_q, retrig_q, tog_q, tc_q, armed_q};
          default:        o_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule // cmcl_counter
`default_nettype wire

// file: tb/cmcl_counter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmcl_map.vh"
module cmcl_counter_asserts (
  input wire logic        i_mclk,   // system clock
  input wire logic        i_rstn,   // synchronous reset, active low
  input wire logic [7:0]  i_addr,   // register address
  input wire logic [15:0] i_wdata,  // write data
  input wire logic        i_wr,     // write strobe
  input wire logic        i_rd,     // read strobe
  input wire logic [15:0] o_rdata,  // read data
  input wire logic        o_tc,     // terminal count
  input wire logic        o_out,    // result pin level
  input wire logic        o_out_oe  // result pin enable
);
  logic [15:0] mode_q;
  logic        rst_q;
  logic [2:0]  oc;
  assign oc = mode_q[2:0];
  // shadow of the mode register, so output checks know the selected form
  always_ff @(posedge i_mclk) begin
    rst_q <= !i_rstn;
    if (!i_rstn) begin
      mode_q <= `CMCL_MODE_RST;
    end else if (i_wr && i_addr == `CMCL_A_MODE) begin
      mode_q <= i_wdata;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence s_set; i_wr && i_addr == `CMCL_A_CMD && i_wdata[7:6] == 2'b01; endsequence
  sequence s_clr; i_wr && i_addr == `CMCL_A_CMD && i_wdata[7:6] == 2'b10; endsequence
  chk_reset_out: assert property (rst_q |-> o_out_oe && !o_out && !o_tc)
    else $error("outputs not at reset values");
  chk_mode_read: assert property (
    i_rd && i_addr == `CMCL_A_MODE |=> o_rdata == mode_q)
    else $error("mode readback wrong");
  chk_off_hiz: assert property (oc == `CMCL_OUT_OFF |=> !o_out_oe)
    else $error("off form still drives");
  chk_drive_low: assert property (oc inside {3'h0, 3'h3, 3'h6, 3'h7} |=> o_out_oe && !o_out)
    else $error("low form not driven low");
  chk_tc_high: assert property (oc == `CMCL_OUT_TCH |=> o_out_oe && o_out == o_tc)
    else $error("high pulse form wrong");
  chk_tc_low: assert property (oc == `CMCL_OUT_TCL |=> o_out_oe && o_out == !o_tc)
    else $error("low pulse form wrong");
  chk_toggle_trail: assert property (
    $fell(o_tc) && oc == `CMCL_OUT_TOG |=> o_out != $past(o_out))
    else $error("toggle missed at end of terminal count");
  chk_set_out: assert property (s_set ##1 oc == `CMCL_OUT_TOG |=> o_out)
    else $error("set output failed");
  chk_clear_out: assert property (s_clr ##1 oc == `CMCL_OUT_TOG |=> !o_out)
    else $error("clear output failed");
endmodule // cmcl_counter_asserts
`default_nettype wire

// file: tb/cmcl_pins.sv
`timescale 1ns/1ps
`default_nettype none
module cmcl_pins (
  input  wire logic       i_mclk,  // system clock
  input  wire logic       i_kick,  // request one source pulse
  input  wire logic       i_gate,  // level for every gate pin
  output var  logic [4:0] o_src,   // source pins, idle low
  output var  logic [4:0] o_gate,  // gate pins
  output var  logic       o_busy   // pulse under way
);
  logic [4:0] cnt_q = 5'h00;
  // 8 cycles high then 8 low, long enough for the pin synchroniser
  always @(posedge i_mclk) begin
    if (i_kick) begin
      cnt_q <= 5'h10;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
  assign o_src  = {4'h0, cnt_q > 5'h08};
  assign o_gate = {5{i_gate}};
  assign o_busy = cnt_q != 5'h00;
endmodule // cmcl_pins
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmcl_map.vh"
module tb;
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] load;
    logic [3:0]  n;
    logic [2:0]  ex;
    logic [15:0] cnt;
  } cmcl_row_t;
  // ex is {tc, drive enable, driven level}
  localparam cmcl_row_t rows [7] = '{
    '{16'h0121, 16'h0002, 4'h2, 3'h7, 16'h0002},
    '{16'h0125, 16'h0003, 4'h2, 3'h3, 16'h0001},
    '{16'h0128, 16'hFFFF, 4'h1, 3'h6, 16'hFFFF},
    '{16'h013D, 16'h9999, 4'h1, 3'h6, 16'h9999},
    '{16'h0129, 16'h9999, 4'h1, 3'h2, 16'h999A},
    '{16'h0121, 16'h0001, 4'h2, 3'h7, 16'h0001},
    '{16'h0124, 16'h0005, 4'h1, 3'h0, 16'h0004}};
  localparam logic [15:0] gm [4] = '{16'h8120, 16'h8120, 16'hA120, 16'hA120};
  localparam logic        gl [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  localparam logic [15:0] ge [4] = '{16'h0005, 16'h0004, 16'h0004, 16'h0003};
  logic        i_mclk  = 1'b0;
  logic        i_rstn  = 1'b0;
  logic [7:0]  i_addr  = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic        kick    = 1'b0;
  logic        gate    = 1'b0;
  logic [4:0]  src;
  logic [4:0]  gates;
  logic        busy;
  logic [15:0] o_rdata;
  logic        o_tc;
  logic        o_out;
  logic        o_out_oe;
  logic [15:0] d;
  int          mismatches  = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  cmcl_counter #(.CTR_IDX(0), .NCTR(5)) DUT (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_freq(5'h00),
    .i_src_pins(src), .i_gate_pins(gates), .i_lower_tc(1'b0),
    .o_tc(o_tc), .o_out(o_out), .o_out_oe(o_out_oe));
  cmcl_pins ext (.i_mclk(i_mclk), .i_kick(kick), .i_gate(gate), .o_src(src),
    .o_gate(gates), .o_busy(busy));
  always #12.5 i_mclk = ~i_mclk;
  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst();
    i_rstn <= 1'b0;
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    v = o_rdata;
    @(posedge i_mclk);
  endtask
  // one whole source pulse per step, then time for the synchroniser to drain
  task automatic pulse(input logic [3:0] n);
    repeat (n) begin
      kick <= 1'b1;
      @(posedge i_mclk);
      kick <= 1'b0;
      @(posedge i_mclk);
      while (busy) @(posedge i_mclk);
      repeat (3) @(posedge i_mclk);
    end
  endtask
  task automatic pin(input logic [2:0] ex);
    @(negedge i_mclk);
    chk({13'h0, o_tc, o_out_oe, o_out & o_out_oe}, {13'h0, ex});
    @(posedge i_mclk);
  endtask
  initial begin
    foreach (rows[i]) begin
      rst();
      wr(`CMCL_A_MODE, rows[i].mode);
      wr(`CMCL_A_LOAD, rows[i].load);
      wr(`CMCL_A_CMD, 16'h0004);
      pulse(rows[i].n);
      pin(rows[i].ex);
      rd(`CMCL_A_COUNT, d);
      chk(d, rows[i].cnt);
    end
    rst();
    rd(`CMCL_A_MODE, d);
    chk(d, `CMCL_MODE_RST);
    wr(`CMCL_A_HOLD, 16'hA5C3);
    rd(`CMCL_A_HOLD, d);
    chk(d, 16'hA5C3);
    rd(8'h18, d);
    chk(d, 16'h0000);
    wr(`CMCL_A_MODE, 16'h0122);
    wr(`CMCL_A_LOAD, 16'h0002);
    wr(`CMCL_A_CMD, 16'h0080);
    wr(`CMCL_A_CMD, 16'h0004);
    pulse(3);
    pin(3'h3);
    pulse(2);
    pin(3'h2);
    wr(`CMCL_A_CMD, 16'h0040);
    pin(3'h3);
    wr(`CMCL_A_CMD, 16'h0080);
    pin(3'h2);
    rst();
    wr(`CMCL_A_MODE, 16'h0101);
    wr(`CMCL_A_LOAD, 16'h0002);
    wr(`CMCL_A_CMD, 16'h0004);
    pulse(3);
    rd(`CMCL_A_STATUS, d);
    chk(d & 16'h0001, 16'h0000);
    rd(`CMCL_A_COUNT, d);
    chk(d, 16'h0001);
    pulse(1);
    rd(`CMCL_A_COUNT, d);
    chk(d, 16'h0001);
    rst();
    wr(`CMCL_A_MODE, 16'h0121);
    wr(`CMCL_A_LOAD, 16'h0003);
    wr(`CMCL_A_CMD, 16'h0004);
    pulse(2);
    wr(`CMCL_A_CMD, 16'h0002);
    pin(3'h7);
    wr(`CMCL_A_CMD, 16'h0002);
    pin(3'h2);
    rst();
    wr(`CMCL_A_LOAD, 16'h0005);
    wr(`CMCL_A_CMD, 16'h0004);
    foreach (gm[i]) begin
      gate <= gl[i];
      wr(`CMCL_A_CMD, 16'h0020);
      wr(`CMCL_A_MODE, gm[i]);
      wr(`CMCL_A_CMD, 16'h0001);
      pulse(1);
      rd(`CMCL_A_COUNT, d);
      chk(d, ge[i]);
    end
    // gate level picks hold (high) or load (low) as reload source
    rst();
    gate <= 1'b1;
    wr(`CMCL_A_MODE, 16'h01E1);
    wr(`CMCL_A_LOAD, 16'h0002);
    wr(`CMCL_A_HOLD, 16'h0009);
    wr(`CMCL_A_CMD, 16'h0004);
    rd(`CMCL_A_COUNT, d);
    chk(d, 16'h0009);
    gate <= 1'b0;
    wr(`CMCL_A_LOAD, 16'h0002);
    wr(`CMCL_A_LOAD, 16'h0002);
    wr(`CMCL_A_CMD, 16'h0002);
    rd(`CMCL_A_COUNT, d);
    chk(d, 16'h0002);
    stop_test();
  end
endmodule // tb
bind cmcl_counter cmcl_counter_asserts u_chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tc(o_tc), .o_out(o_out),
  .o_out_oe(o_out_oe));
`default_nettype wire
